/* File: rtl/bsf_monitor.sv */
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module bsf_monitor
  import bsf_pkg::*;
#(
  parameter int TACH_WIN_CYC = TACH_WIN_MS * (CLK_HZ / 1000),
  parameter int KICK_CYC = KICK_MS * (CLK_HZ / 1000),
  parameter int BEEP_CYC = BEEP_TONE_US * (CLK_HZ / 1_000_000)
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_TEMP-1:0][7:0] temp_i,
  input wire logic [N_VOLT-1:0][7:0] volt_i,
  input wire logic [N_TERM-1:0][7:0] term_i,
  input wire logic [4:0] code_a_i,
  input wire logic [4:0] code_b_i,
  input wire logic core_reg_only_i,
  input wire logic [N_FAN-1:0] fan_i,
  input wire logic [4:0] fan_pack_i,
  input wire logic [1:0] cpu_present_i,
  input wire logic [1:0] term_mod_i,
  input wire logic sys_pwr_i,
  input wire logic hard_rst_i,
  input wire logic ac_ok_i,
  input wire logic power_req_i,
  output logic power_en_o,
  output logic pwm_o,
  output logic speaker_o,
  output logic event_o
);
  logic [1:0] ctrl;
  logic [5:0] fan_pop;
  logic [5:0] fan_dig;
  logic [7:0] fan_crit;
  logic [7:0] peer;
  logic [9:0] evt;
  logic [15:0] pwm_tab [N_PWM];
  logic [31:0] thr [N_TEMP+N_VOLT];
  logic [5:0] fan_en;
  logic [5:0] fan_fail;
  logic [3:0] term_fail;
  logic [N_FAN-1:0][7:0] tach;
  logic [N_FAN-1:0] fan_src;
  logic [5:0] next_fan_fail;
  logic [3:0] next_term_fail;
  logic [9:0] evt_set;
  logic [3:0] temp_crit, temp_nc;
  logic [9:0] volt_crit, volt_nc;
  logic overtemp, fail_spd, kick, high_spd;
  logic [31:0] kick_cnt;
  logic [31:0] win_cnt;
  logic win;
  logic pwr_d, init_p;
  logic mismatch;
  logic [1:0] missing;
  logic beep_act, tone;
  logic [3:0] cad;
  logic [31:0] beep_cnt;
  logic [7:0] duty, next_duty;
  logic [31:0] rdata;
  logic acc, wr;

  function automatic logic [31:0] bsf_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    return old;
  endfunction

  // Returns {high crit, high non-crit, low non-crit, low crit}; m gates {upper, lower}.
  function automatic logic [3:0] bsf_eval(input logic [7:0] r, input logic [31:0] t, input logic [1:0] m);
    return {r >= t[THR_HC +: 8], r >= t[THR_HN +: 8], r <= t[THR_LN +: 8], r <= t[THR_LC +: 8]}
           & {m[1], m[1], m[0], m[0]};
  endfunction

  function automatic logic [31:0] bsf_auto_thr(input logic [4:0] code);
    logic [7:0] nom;
    nom = CODE_BASE - 8'(code * CODE_STEP);
    return {nom + CODE_C_MARGIN, nom + CODE_NC_MARGIN, nom - CODE_NC_MARGIN, nom - CODE_C_MARGIN};
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      fan_pop <= FAN_POP_RST;
      fan_dig <= FAN_DIG_RST;
      fan_crit <= FAN_CRIT_RST;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl <= 2'(bsf_merge(32'(ctrl), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == ADR_FAN_CFG) begin
        {fan_dig, fan_pop} <= 12'(bsf_merge(32'({fan_dig, fan_pop}), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == ADR_FAN_CRIT) begin
        fan_crit <= 8'(bsf_merge(32'(fan_crit), wb_dat_i, wb_sel_i));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_PWM; i++) begin
        pwm_tab[i] <= PWM_TAB_RST;
      end
      for (int i = 0; i < N_TEMP + N_VOLT; i++) begin
        thr[i] <= THR_RST;
      end
    end else if (wr) begin
      if (wb_adr_i[7:4] == ADR_PWM_HI) begin
        pwm_tab[wb_adr_i[3:2]] <= 16'(bsf_merge(32'(pwm_tab[wb_adr_i[3:2]]), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i[7:6] == ADR_THR_HI && int'(wb_adr_i[5:2]) < N_TEMP + N_VOLT) begin
        thr[wb_adr_i[5:2]] <= bsf_merge(thr[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
      end
    end
  end

  // Each bit is one peer's fault report; AC loss forgets all of them.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ac_ok_i) begin
      peer <= 8'h00;
    end else if (wr && wb_adr_i == ADR_PEER) begin
      peer <= 8'(bsf_merge(32'(peer), wb_dat_i, wb_sel_i));
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt <= 10'h000;
      event_o <= 1'b0;
    end else begin
      evt <= (wr && wb_adr_i == ADR_EVENT) ? ((evt & ~wb_dat_i[9:0]) | evt_set) : (evt | evt_set);
      event_o <= |evt_set;
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      ADR_CTRL: rdata = 32'(ctrl);
      ADR_FAN_CFG: rdata = 32'({fan_dig, fan_pop});
      ADR_FAN_CRIT: rdata = 32'(fan_crit);
      ADR_PEER: rdata = 32'(peer);
      ADR_STATUS: rdata = 32'({fan_en, missing, high_spd, mismatch, term_fail, fan_fail});
      ADR_EVENT: rdata = 32'(evt);
      ADR_TEMP_ST: rdata = 32'({temp_nc, temp_crit});
      ADR_VOLT_ST: rdata = 32'({volt_nc, volt_crit});
      ADR_TACH_LO: rdata = {tach[3], tach[2], tach[1], tach[0]};
      ADR_TACH_HI: rdata = 32'({tach[5], tach[4]});
      default: begin
        rdata = 32'h00000000;
        if (wb_adr_i[7:4] == ADR_PWM_HI) begin
          rdata = 32'(pwm_tab[wb_adr_i[3:2]]);
        end else if (wb_adr_i[7:6] == ADR_THR_HI && int'(wb_adr_i[5:2]) < N_TEMP + N_VOLT) begin
          rdata = thr[wb_adr_i[5:2]];
        end
      end
    endcase
  end

  always_comb begin
    logic [3:0] st;
    st = 4'h0;
    for (int i = 0; i < N_TEMP; i++) begin
      st = bsf_eval(temp_i[i], thr[i], (ctrl[CTRL_AUTO] && i >= 2) ? 2'b10 : 2'b11);
      temp_crit[i] = st[3] | st[0];
      temp_nc[i] = st[2] | st[1];
    end
    for (int i = 0; i < N_VOLT; i++) begin
      st = bsf_eval(volt_i[i], (i == VPROC_IDX && core_reg_only_i) ? bsf_auto_thr(code_a_i)
                    : thr[N_TEMP+i], 2'b11);
      volt_crit[i] = st[3] | st[0];
      volt_nc[i] = st[2] | st[1];
    end
  end

  // Over-temperature is any enabled temperature threshold crossed, lower ones included; ambient table steps do not count here.
  assign overtemp = |temp_nc[3:0] || |temp_crit;
  assign fan_src = ctrl[CTRL_PACK] ? {1'b0, fan_pack_i} : fan_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || win) begin
      win_cnt <= 32'h00000000;
    end else begin
      win_cnt <= win_cnt + 32'h00000001;
    end
  end
  assign win = (win_cnt == 32'(TACH_WIN_CYC - 1));

  for (genvar g = 0; g < N_FAN; g++) begin : g_tach
    bsf_tach u_tach (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fan_i(fan_src[g]),
      .win_i(win),
      .reading_o(tach[g])
    );
  end

  always_comb begin
    for (int i = 0; i < N_FAN; i++) begin
      // A populated tach-mode connector with no fan reads zero speed and fails; a digital connector fails only while its line is high.
      next_fan_fail[i] = fan_en[i] && (fan_dig[i] ? fan_src[i] : (tach[i] < fan_crit));
    end
    for (int i = 0; i < N_TERM; i++) begin
      next_term_fail[i] = !(term_i[i] >= TERM_SE_LO && term_i[i] <= TERM_SE_HI)
                          && !(term_i[i] >= TERM_LVD_LO && term_i[i] <= TERM_LVD_HI);
    end
  end
  assign evt_set = {next_term_fail & ~term_fail, next_fan_fail & ~fan_fail};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fan_fail <= 6'h00;
      term_fail <= 4'h0;
    end else begin
      fan_fail <= next_fan_fail;
      term_fail <= next_term_fail;
    end
  end

  assign init_p = (sys_pwr_i && !pwr_d) || hard_rst_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_d <= 1'b0;
      fan_en <= 6'h00;
    end else begin
      pwr_d <= sys_pwr_i;
      if (init_p) begin
        fan_en <= fan_pop & (ctrl[CTRL_PACK] ? PACK_MASK : 6'h3F);
      end
    end
  end

  // Cleared only when no local fan and no peer is critical; AC loss clears it outright.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ac_ok_i) begin
      fail_spd <= 1'b0;
    end else begin
      fail_spd <= |fan_fail || |peer;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !sys_pwr_i) begin
      kick_cnt <= 32'h00000000;
    end else if (!pwr_d) begin
      kick_cnt <= 32'(KICK_CYC);
    end else if (kick_cnt != 32'h00000000) begin
      kick_cnt <= kick_cnt - 32'h00000001;
    end
  end
  assign kick = (kick_cnt != 32'h00000000);

  assign high_spd = fail_spd || overtemp || kick;

  always_comb begin
    next_duty = DUTY_MIN;
    for (int j = 0; j < N_PWM; j++) begin
      if (temp_i[AMB_IDX] >= pwm_tab[j][7:0]) begin
        next_duty = pwm_tab[j][TAB_DUTY +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty <= DUTY_FULL;
    end else begin
      duty <= high_spd ? DUTY_FULL : next_duty;
    end
  end

  bsf_pwm u_pwm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .duty_i(duty),
    .pwm_o(pwm_o)
  );

  assign mismatch = (code_a_i != code_b_i);
  assign missing = ~(cpu_present_i | term_mod_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_en_o <= 1'b0;
      beep_act <= 1'b0;
    end else begin
      power_en_o <= power_req_i && !mismatch;
      beep_act <= power_req_i && (mismatch || |missing);
    end
  end

  // Tone toggles each half period; the cadence counter splits it into beep bursts.
  always_ff @(posedge clk_i) begin
    if (rst_i || !beep_act) begin
      beep_cnt <= 32'h00000000;
      tone <= 1'b0;
      cad <= 4'h0;
      speaker_o <= 1'b0;
    end else begin
      speaker_o <= tone && !cad[3];
      if (beep_cnt == 32'(BEEP_CYC - 1)) begin
        beep_cnt <= 32'h00000000;
        tone <= !tone;
        cad <= cad + {3'h0, tone};
      end else begin
        beep_cnt <= beep_cnt + 32'h00000001;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_mismatch_block; mismatch |=> !power_en_o; endproperty
  a_mismatch_block: assert property (p_mismatch_block) else $error("power enabled with code mismatch");
  property p_beep; (power_req_i && |missing) |=> beep_act; endproperty
  a_beep: assert property (p_beep) else $error("no beep for empty socket");
  property p_ac_clear; !ac_ok_i |=> !fail_spd && peer == 8'h00; endproperty
  a_ac_clear: assert property (p_ac_clear) else $error("speed-up kept over AC loss");
  property p_fan_high; (|next_fan_fail && ac_ok_i) ##1 ac_ok_i |=> ##1 duty == DUTY_FULL; endproperty
  a_fan_high: assert property (p_fan_high) else $error("fan failure did not force full duty");
  property p_peer_high; (|peer && ac_ok_i) |=> ##1 duty == DUTY_FULL; endproperty
  a_peer_high: assert property (p_peer_high) else $error("peer fault did not force full duty");
  property p_low_ok; (!fail_spd && !overtemp && !kick) |=> duty == $past(next_duty); endproperty
  a_low_ok: assert property (p_low_ok) else $error("duty not from table when clear");
  property p_kick; (sys_pwr_i && !pwr_d) |=> kick [*8]; endproperty
  a_kick: assert property (p_kick) else $error("kick start missing after power-up");
  property p_init; (init_p && !ctrl[CTRL_PACK]) |=> fan_en == $past(fan_pop); endproperty
  a_init: assert property (p_init) else $error("fans not enabled on init");
  property p_term_evt; (next_term_fail[0] && !term_fail[0]) |=> evt[6] && event_o; endproperty
  a_term_evt: assert property (p_term_evt) else $error("terminator event lost");
  property p_pack; (init_p && ctrl[CTRL_PACK]) |=> !fan_en[5]; endproperty
  a_pack: assert property (p_pack) else $error("sixth fan used in pack mode");
  property p_wb_ack; acc |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not single cycle");

  c_mismatch: cover property (power_req_i && mismatch ##1 speaker_o == 1'b0);
  c_term: cover property (next_term_fail[0] && !term_fail[0]);
  c_peer: cover property (|peer ##2 duty == DUTY_FULL);
  c_kick_end: cover property (kick ##1 !kick);
endmodule

/* File: rtl/bsf_pkg.sv */
package bsf_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TACH_WIN_MS = 100;
  localparam int KICK_MS = 2000;
  localparam int BEEP_TONE_US = 500;
  localparam int PWM_STEP_NS = 1000;
  localparam int PWM_STEP_CYC = PWM_STEP_NS / (1_000_000_000 / CLK_HZ);
  localparam int N_TEMP = 4;
  localparam int N_VOLT = 10;
  localparam int N_FAN = 6;
  localparam int N_TERM = 4;
  localparam int N_PWM = 4;
  localparam int AMB_IDX = 1;
  localparam int VPROC_IDX = 4;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FAN_CFG = 8'h04;
  localparam logic [7:0] ADR_FAN_CRIT = 8'h08;
  localparam logic [7:0] ADR_PEER = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_EVENT = 8'h14;
  localparam logic [7:0] ADR_TEMP_ST = 8'h18;
  localparam logic [7:0] ADR_VOLT_ST = 8'h1C;
  localparam logic [7:0] ADR_TACH_LO = 8'h20;
  localparam logic [7:0] ADR_TACH_HI = 8'h24;
  localparam logic [3:0] ADR_PWM_HI = 4'h4;
  localparam logic [1:0] ADR_THR_HI = 2'h2;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PACK = 1;
  localparam int CFG_DIG = 6;
  localparam int THR_LC = 0;
  localparam int THR_LN = 8;
  localparam int THR_HN = 16;
  localparam int THR_HC = 24;
  localparam int TAB_DUTY = 8;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [5:0] FAN_POP_RST = 6'h3F;
  localparam logic [5:0] FAN_DIG_RST = 6'h00;
  localparam logic [5:0] PACK_MASK = 6'h1F;
  localparam logic [7:0] FAN_CRIT_RST = 8'h10;
  localparam logic [31:0] THR_RST = 32'hFFFE0100;
  localparam logic [15:0] PWM_TAB_RST = 16'h80FF;
  localparam logic [7:0] DUTY_MIN = 8'h40;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] CODE_BASE = 8'hC0;
  localparam logic [7:0] CODE_STEP = 8'h04;
  localparam logic [7:0] CODE_NC_MARGIN = 8'h08;
  localparam logic [7:0] CODE_C_MARGIN = 8'h10;
  localparam logic [7:0] TERM_SE_LO = 8'hA0;
  localparam logic [7:0] TERM_SE_HI = 8'hD0;
  localparam logic [7:0] TERM_LVD_LO = 8'h50;
  localparam logic [7:0] TERM_LVD_HI = 8'h80;
endpackage

/* File: rtl/bsf_tach.sv */
`timescale 1ns/1ps
module bsf_tach
  import bsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fan_i,
  input wire logic win_i,
  output logic [7:0] reading_o
);
  logic fan_d;
  logic rise;
  logic [7:0] cnt;

  assign rise = fan_i && !fan_d;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fan_d <= 1'b0;
    end else begin
      fan_d <= fan_i;
    end
  end

  // Rising edges are counted per window; the count saturates at full scale.
  // An edge in the closing cycle of a window opens the next count, so that no edge is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else if (win_i) begin
      cnt <= {7'h00, rise};
    end else if (rise && cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end

  // Full scale until the first window avoids a false failure after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reading_o <= 8'hFF;
    end else if (win_i) begin
      reading_o <= cnt;
    end
  end
endmodule

/* File: rtl/bsf_pwm.sv */
`timescale 1ns/1ps
module bsf_pwm
  import bsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] duty_i,
  output logic pwm_o
);
  logic [15:0] div;
  logic [7:0] phase;
  logic step;

  assign step = (div == 16'(PWM_STEP_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || step) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 8'h00;
    end else if (step) begin
      phase <= phase + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_o <= 1'b1;
    end else begin
      pwm_o <= (duty_i == DUTY_FULL) || (phase < duty_i);
    end
  end
endmodule

/* File: test/bsf_fan_model.sv */
`timescale 1ns/1ps
module bsf_fan_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] spin_i,
  input wire logic [5:0] dig_i,
  input wire logic [5:0] lag_i,
  output logic [5:0] fan_o
);
  logic tach;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tach <= 1'b0;
    end else begin
      tach <= ~tach;
    end
  end
  // A stopped or absent tach fan leaves its pulled-down line low.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      fan_o[i] = dig_i[i] ? lag_i[i] : (spin_i[i] & tach);
    end
  end
endmodule

/* File: test/tb_bsf_monitor.sv */
`timescale 1ns/1ps
module tb_bsf_monitor;
  import bsf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [N_TEMP-1:0][7:0] temp = {N_TEMP{8'h80}};
  logic [N_VOLT-1:0][7:0] volt = {N_VOLT{8'h80}};
  logic [N_TERM-1:0][7:0] term = {N_TERM{8'h60}};
  logic [4:0] code_a = 5'h00;
  logic [4:0] code_b = 5'h00;
  logic [5:0] spin = 6'h3F;
  logic [5:0] dig = 6'h00;
  logic [5:0] lag = 6'h00;
  logic [5:0] fan;
  logic [1:0] cpu = 2'h3;
  logic [1:0] tmod = 2'h0;
  logic core_reg_only = 1'b0;
  logic sys_pwr = 1'b0;
  logic hrst = 1'b0;
  logic ac_ok = 1'b1;
  logic preq = 1'b0;
  logic pen, pwm, spk, evt, spk_q;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int evts = 0;
  int edges = 0;
  int lows = 0;
  int e0;

  bsf_monitor #(.TACH_WIN_CYC(64), .KICK_CYC(20), .BEEP_CYC(4)) u_bsf_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .temp_i(temp), .volt_i(volt),
    .term_i(term), .code_a_i(code_a), .code_b_i(code_b), .core_reg_only_i(core_reg_only), .fan_i(fan),
    .fan_pack_i(fan[4:0]), .cpu_present_i(cpu), .term_mod_i(tmod), .sys_pwr_i(sys_pwr), .hard_rst_i(hrst),
    .ac_ok_i(ac_ok), .power_req_i(preq), .power_en_o(pen), .pwm_o(pwm), .speaker_o(spk), .event_o(evt));

  bsf_fan_model u_bsf_fan_model (
    .clk_i(clk_i), .rst_i(rst_i), .spin_i(spin), .dig_i(dig), .lag_i(lag), .fan_o(fan));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    spk_q <= spk;
    if (evt === 1'b1) evts++;
    if (spk !== spk_q) edges++;
    if (pwm === 1'b0) lows++;
    if (cycles == 80000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    chk("bus ack low", 32'h0, {31'h0, ack});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    repeat (3) @(posedge clk_i);
    wb(1'b0, a, 32'h0);
    chk(n, e, q & m);
  endtask

  task automatic hard_reset();
    @(posedge clk_i);
    hrst <= 1'b1;
    @(posedge clk_i);
    hrst <= 1'b0;
    repeat (200) @(posedge clk_i);
  endtask

  // Counts low PWM cycles over more than one full 8-bit PWM period.
  task automatic pwm_low(input logic e, input string n);
    lows = 0;
    repeat (26000) @(posedge clk_i);
    chk(n, {31'h0, e}, {31'h0, lows != 0});
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
    rd(ADR_FAN_CFG, 32'hFFF, 32'h3F, "fan cfg");
    rd(ADR_FAN_CRIT, 32'hFF, 32'h10, "fan crit");
    rd(8'h80, 32'hFFFFFFFF, 32'hFFFE0100, "threshold");
    rd(8'h40, 32'hFFFF, 32'h80FF, "pwm table");
    rd(8'hFC, 32'hFFFFFFFF, 32'h0, "unmapped");
    rd(ADR_STATUS, 32'hFC000, 32'h0, "fans disabled");
    @(posedge clk_i);
    sys_pwr <= 1'b1;
    rd(ADR_STATUS, 32'h800, 32'h800, "kick start");
    repeat (40) @(posedge clk_i);
    rd(ADR_STATUS, 32'hFC800, 32'hFC000, "after kick");
    repeat (200) @(posedge clk_i);
    rd(ADR_TACH_LO, 32'hFFFFFFFF, 32'h20202020, "tach");
    pwm_low(1'b1, "pwm low speed");
    wb(1'b1, ADR_CTRL, 32'h2);
    hard_reset();
    rd(ADR_STATUS, 32'hFC03F, 32'h7C000, "pack mode");
    wb(1'b1, ADR_CTRL, 32'h0);
    hard_reset();
    wb(1'b1, ADR_EVENT, 32'h3FF);
    e0 = evts;
    @(posedge clk_i);
    spin[5] <= 1'b0;
    repeat (200) @(posedge clk_i);
    rd(ADR_STATUS, 32'h83F, 32'h820, "missing fan");
    rd(ADR_EVENT, 32'h3F, 32'h20, "fan event");
    chk("event pulses", 32'h1, evts - e0);
    wb(1'b1, ADR_FAN_CFG, 32'h11F);
    dig[2] <= 1'b1;
    hard_reset();
    rd(ADR_STATUS, 32'hFC83F, 32'h7C000, "unpopulated");
    @(posedge clk_i);
    lag[2] <= 1'b1;
    rd(ADR_STATUS, 32'h83F, 32'h804, "digital fan");
    @(posedge clk_i);
    lag[2] <= 1'b0;
    rd(ADR_STATUS, 32'h83F, 32'h0, "digital ok");
    wb(1'b1, ADR_PEER, 32'h1);
    rd(ADR_STATUS, 32'h800, 32'h800, "peer fault");
    wb(1'b1, ADR_PEER, 32'h0);
    rd(ADR_STATUS, 32'h800, 32'h0, "peer clear");
    wb(1'b1, ADR_PEER, 32'h1);
    @(posedge clk_i);
    ac_ok <= 1'b0;
    repeat (2) @(posedge clk_i);
    ac_ok <= 1'b1;
    rd(ADR_STATUS, 32'h800, 32'h0, "ac loss");
    wb(1'b1, ADR_FAN_CRIT, 32'h21);
    repeat (200) @(posedge clk_i);
    rd(ADR_STATUS, 32'h3F, 32'h1B, "tach below crit");
    wb(1'b1, ADR_FAN_CRIT, 32'h10);
    repeat (200) @(posedge clk_i);
    wb(1'b1, 8'h88, 32'h90882010);
    @(posedge clk_i);
    temp[2] <= 8'h88;
    rd(ADR_TEMP_ST, 32'hFF, 32'h40, "temp noncrit");
    rd(ADR_STATUS, 32'h800, 32'h800, "overtemp");
    @(posedge clk_i);
    temp[2] <= 8'h90;
    rd(ADR_TEMP_ST, 32'hFF, 32'h44, "temp crit");
    @(posedge clk_i);
    temp[2] <= 8'h80;
    temp[3] <= 8'h00;
    rd(ADR_TEMP_ST, 32'hFF, 32'h88, "temp low");
    wb(1'b1, ADR_CTRL, 32'h1);
    rd(ADR_TEMP_ST, 32'hFF, 32'h0, "auto upper only");
    wb(1'b1, ADR_CTRL, 32'h0);
    @(posedge clk_i);
    temp[3] <= 8'h80;
    volt[9] <= 8'h00;
    rd(ADR_VOLT_ST, 32'hFFFFF, 32'h80200, "volt crit");
    @(posedge clk_i);
    volt[9] <= 8'hFE;
    rd(ADR_VOLT_ST, 32'hFFFFF, 32'h80000, "volt noncrit");
    @(posedge clk_i);
    volt[9] <= 8'h80;
    core_reg_only <= 1'b1;
    code_a <= 5'h02;
    volt[4] <= 8'hB8;
    rd(ADR_VOLT_ST, 32'hFFFFF, 32'h0, "auto volt nominal");
    @(posedge clk_i);
    volt[4] <= 8'hC4;
    rd(ADR_VOLT_ST, 32'hFFFFF, 32'h4000, "auto volt noncrit");
    @(posedge clk_i);
    volt[4] <= 8'hD0;
    rd(ADR_VOLT_ST, 32'hFFFFF, 32'h4010, "auto volt crit");
    wb(1'b1, ADR_EVENT, 32'h3FF);
    e0 = evts;
    for (int k = 0; k < N_TERM; k++) begin
      @(posedge clk_i);
      term[k] <= 8'h90;
      rd(ADR_STATUS, 32'h3C0, 32'h40 << k, "term fail");
      @(posedge clk_i);
      term[k] <= 8'hB0;
      rd(ADR_STATUS, 32'h3C0, 32'h0, "term ok");
    end
    rd(ADR_EVENT, 32'h3C0, 32'h3C0, "term events");
    chk("term pulses", 32'h4, evts - e0);
    @(posedge clk_i);
    code_b <= 5'h02;
    preq <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("power on", 32'h1, {31'h0, pen});
    code_b <= 5'h03;
    rd(ADR_STATUS, 32'h400, 32'h400, "code mismatch");
    edges = 0;
    repeat (400) @(posedge clk_i);
    chk("power blocked", 32'h0, {31'h0, pen});
    chk("mismatch beep", 32'h1, {31'h0, edges != 0});
    code_b <= 5'h02;
    cpu <= 2'h1;
    rd(ADR_STATUS, 32'h3000, 32'h2000, "empty socket");
    edges = 0;
    repeat (400) @(posedge clk_i);
    chk("socket beep", 32'h1, {31'h0, edges != 0});
    tmod <= 2'h2;
    repeat (40) @(posedge clk_i);
    edges = 0;
    repeat (400) @(posedge clk_i);
    chk("no beep", 32'h0, {31'h0, edges != 0});
    wb(1'b1, ADR_EVENT, 32'h3FF);
    wb(1'b1, 8'h40, 32'hFF70);
    rd(ADR_STATUS, 32'h83F, 32'h0, "ambient no warning");
    rd(ADR_EVENT, 32'h3F, 32'h0, "ambient no event");
    pwm_low(1'b0, "pwm ambient step");
    complete_run();
  end
endmodule
